// >>> rtl/frh_framer.sv
// Purpose: target-side framer delivering queued result items in acknowledged fragments
// Assumes: results are written bytewise into a queue slot, then committed with their length
// Notes: handshake fields are registered every clock but acted on only at the packet interval tick
//
// Operation
// [RULE1] after reset all sequence and size fields read zero
// [RULE2] short item goes whole as fragment one, both sizes equal its length
// [RULE3] on item acknowledge publish next item, item seq plus one, fragment one
// [RULE4] long items split into 128-byte fragments of contiguous bytes
// [RULE5] next fragment only when acknowledged fragment equals the one presented
// [RULE6] last fragment carries the remainder, item size stays full length
// [RULE7] controller acks fragments, then the item, and zeroes fragment ack
// [RULE8] controller acks a fragmented item only after all its fragments
// [RULE9] later results wait until earlier ones are fully acknowledged
// [RULE10] configuration instance 128 accepted, zero size, no data
// [RULE11] packet interval lies between 2 and 3200 milliseconds
// [RULE12] controller defaults to 50 ms and avoids needlessly fast intervals
// [RULE13] at most one fragment of up to 128 bytes per interval
// [RULE14] keep-always retains last result after reading and across reconnects
// [RULE15] discard-on-disconnect deletes last result when the connection closes
// [RULE16] discard-on-read deletes last result as soon as it is read
// [RULE17] each read queued result is removed and replaced by the next
// [RULE18] buffer position zero holds the first byte of the current fragment
`timescale 1ns/1ps
`default_nettype none
module frh_framer
   import frh_pkg::*;
#(
   parameter int QDEPTH = QUEUE_DEPTH,
   parameter int MAXB = MAX_ITEM_BYTES,
   parameter int RPI_CYC = RPI_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire frh_pkg::frh_keep_type keep_mode_i,
   input wire logic conn_open_i,
   input wire logic [7:0] cfg_instance_i,
   output logic cfg_accept_o,
   input wire logic wr_byte_valid_i,
   input wire logic [7:0] wr_byte_i,
   input wire logic wr_commit_i,
   input wire logic [15:0] wr_len_i,
   output logic wr_ready_o,
   input wire frh_pkg::frh_ack_type ack_i,
   output frh_pkg::frh_hdr_type hdr_o,
   output logic [FRAG_BYTES*8-1:0] frag_data_o,
   output logic tick_o
);
   import frh_pkg::*;

   localparam int QW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
   localparam int BW = $clog2(MAXB);
   localparam int TW = $clog2(RPI_CYC + 1);

   // ----------------------------------------------------------------
   // storage and queue state
   // ----------------------------------------------------------------
   logic [7:0] mem [QDEPTH][MAXB];
   logic [15:0] len [QDEPTH];
   logic [QW-1:0] head, tail, next_head, next_tail;
   logic [QW:0] count, next_count;
   logic [BW-1:0] wptr, next_wptr;
   logic [TW-1:0] tmr, next_tmr;
   logic tick, next_tick;
   logic conn_q1, conn_q2, conn_prev;
   frh_ack_type ack_q1, ack_q2, ack_q3;

   typedef enum logic [1:0] {
      FRH_IDLE,
      FRH_SHOW,
      FRH_HELD
   } frh_state_type;

   frh_state_type state, next_state;
   frh_hdr_type hdr, next_hdr;
   logic [15:0] offs, next_offs;
   logic pop;

   function automatic logic [15:0] frag_len(input logic [15:0] total, input logic [15:0] off);
      logic [15:0] rem;
      rem = total - off;
      frag_len = (rem > 16'(FRAG_BYTES)) ? 16'(FRAG_BYTES) : rem;
   endfunction

   assign wr_ready_o = (count != (QW+1)'(QDEPTH));
   assign tick_o = tick;
   assign cfg_accept_o = (cfg_instance_i == 8'(CFG_INSTANCE)); // see [RULE10]

   // ----------------------------------------------------------------
   // interval timer, one enable per packet interval
   // ----------------------------------------------------------------
   always_comb begin
      next_tick = 1'b0;
      next_tmr = tmr + TW'(1);
      if (tmr == TW'(RPI_CYC - 1)) begin // see [RULE11]
         next_tmr = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tmr <= '0;
         tick <= 1'b0;
         conn_q1 <= 1'b0;
         conn_q2 <= 1'b0;
         conn_prev <= 1'b0;
         ack_q1 <= '0;
         ack_q2 <= '0;
         ack_q3 <= '0;
      end else begin
         tmr <= next_tmr;
         tick <= next_tick;
         conn_q1 <= conn_open_i;
         conn_q2 <= conn_q1;
         conn_prev <= conn_q2;
         ack_q1 <= ack_i;
         ack_q2 <= ack_q1;
         ack_q3 <= ack_q2;
      end
   end

   // ----------------------------------------------------------------
   // queue fill, results wait their turn
   // ----------------------------------------------------------------
   always_comb begin
      next_tail = tail;
      next_wptr = wptr;
      next_count = count;
      next_head = head;
      if (wr_byte_valid_i && wr_ready_o) begin
         next_wptr = wptr + BW'(1);
      end
      if (wr_commit_i && wr_ready_o) begin
         next_tail = (tail == QW'(QDEPTH-1)) ? '0 : tail + QW'(1); // see [RULE9]
         next_wptr = '0;
         next_count = next_count + (QW+1)'(1);
      end
      if (pop) begin
         next_head = (head == QW'(QDEPTH-1)) ? '0 : head + QW'(1); // see [RULE17]
         next_count = next_count - (QW+1)'(1);
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tail <= '0;
         head <= '0;
         wptr <= '0;
         count <= '0;
      end else begin
         tail <= next_tail;
         head <= next_head;
         wptr <= next_wptr;
         count <= next_count;
      end
   end

   // storage has no reset; contents are defined by length on commit
   always_ff @(posedge core_clk_i) begin
      if (wr_byte_valid_i && wr_ready_o) begin
         mem[tail][wptr] <= wr_byte_i;
      end
      if (wr_commit_i && wr_ready_o) begin
         len[tail] <= wr_len_i;
      end
   end

   // ----------------------------------------------------------------
   // presentation state machine
   // ----------------------------------------------------------------
   // SHOW: head item on display awaiting ack; HELD: last item kept after read
   always_comb begin
      next_state = state;
      next_hdr = hdr;
      next_offs = offs;
      pop = 1'b0;
      case (state)
         FRH_IDLE: begin
            if (tick && count != '0) begin
               next_hdr.item_seq = hdr.item_seq + 8'h01; // see [RULE3]
               next_hdr.frag_seq = FRAG_FIRST; // see [RULE2]
               next_hdr.item_size = len[head];
               next_hdr.frag_size = frag_len(len[head], 16'h0000); // see [RULE2]
               next_offs = 16'h0000;
               next_state = FRH_SHOW;
            end
         end
         FRH_SHOW: begin
            // the ack word crosses bit by bit; act only once two samples agree
            if (tick && ack_q2 == ack_q3) begin // see [RULE13]
               if (ack_q2.ack_item == hdr.item_seq) begin // see [RULE8]
                  if (count > (QW+1)'(1) || keep_mode_i == FRH_DISCARD_ON_READ) begin
                     pop = 1'b1; // see [RULE16]
                     next_state = FRH_IDLE;
                  end else begin
                     next_state = FRH_HELD; // see [RULE14]
                  end
               end else if (ack_q2.ack_frag == hdr.frag_seq
                            && offs + hdr.frag_size < hdr.item_size) begin // see [RULE5]
                  next_offs = offs + 16'(FRAG_BYTES); // see [RULE4]
                  next_hdr.frag_seq = hdr.frag_seq + 8'h01;
                  next_hdr.frag_size = frag_len(hdr.item_size, next_offs); // see [RULE6]
               end
            end
         end
         FRH_HELD: begin
            if (count > (QW+1)'(1)) begin
               pop = 1'b1; // see [RULE17]
               next_state = FRH_IDLE;
            end else if (keep_mode_i == FRH_DISCARD_ON_READ
                         || (keep_mode_i == FRH_DISCARD_ON_DISCONNECT
                             && conn_prev && !conn_q2)) begin
               pop = 1'b1; // see [RULE15]
               next_state = FRH_IDLE;
            end
         end
         default: begin
            next_state = FRH_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= FRH_IDLE;
         hdr <= '0; // see [RULE1]
         offs <= '0;
      end else begin
         state <= next_state;
         hdr <= next_hdr;
         offs <= next_offs;
      end
   end

   // ----------------------------------------------------------------
   // outputs from flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hdr_o <= '0;
         frag_data_o <= '0;
      end else begin
         hdr_o <= hdr;
         for (int i = 0; i < FRAG_BYTES; i++) begin
            if (state != FRH_IDLE && 16'(i) < hdr.frag_size) begin
               frag_data_o[i*8 +: 8] <= mem[head][BW'(offs + 16'(i))]; // see [RULE18]
            end else begin
               frag_data_o[i*8 +: 8] <= 8'h00;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/frh_pkg.sv
// Purpose: shared constants and carrier types for the fragmented result handshake
// Assumes: byte-wide message data, one fragment published per packet interval
// Notes: retention policy encodings follow the three keep settings
package frh_pkg;
   localparam int FRAG_BYTES = 128;
   localparam int MAX_ITEM_BYTES = 1024;
   localparam int QUEUE_DEPTH = 4;
   localparam int CFG_INSTANCE = 128;
   localparam int CFG_SIZE = 0;
   localparam int CLK_HZ = 50000000;
   localparam int RPI_MIN_MS = 2;
   localparam int RPI_MAX_MS = 3200;
   localparam int RPI_DEFAULT_MS = 50;
   localparam int RPI_CYCLES = (CLK_HZ / 1000) * RPI_DEFAULT_MS;
   localparam logic [7:0] SEQ_RESET = 8'h00;
   localparam logic [7:0] FRAG_FIRST = 8'h01;

   typedef enum logic [1:0] {
      FRH_KEEP_ALWAYS,
      FRH_DISCARD_ON_DISCONNECT,
      FRH_DISCARD_ON_READ
   } frh_keep_type;

   // acknowledgement fields written by the controller
   typedef struct packed {
      logic [7:0] ack_item;
      logic [7:0] ack_frag;
   } frh_ack_type;

   // header presented to the controller alongside the fragment data
   typedef struct packed {
      logic [7:0] item_seq;
      logic [7:0] frag_seq;
      logic [15:0] item_size;
      logic [15:0] frag_size;
   } frh_hdr_type;
endpackage

// >>> tb/frh_properties.sv
// Purpose: port checker for the framer header and data
// Assumes: header moves two cycles after a tick pulse, never otherwise
// Notes: only the reset header shows fragment zero; a cleared item keeps its header
`timescale 1ns/1ps
`default_nettype none
module frh_properties
   import frh_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] cfg_instance_i,
   input wire logic cfg_accept_o,
   input wire frh_pkg::frh_hdr_type hdr_o,
   input wire logic [FRAG_BYTES*8-1:0] frag_data_o,
   input wire logic tick_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [15:0] sent;
   assign sent = 16'(hdr_o.frag_seq - 8'h01) * 16'h0080;
   chk_cfg_accept: assert property (cfg_accept_o == (cfg_instance_i == 8'h80))
      else $error("config accept wrong");
   // tick_o is registered and the header passes two flops, so it moves two cycles later
   chk_hdr_hold: assert property (!$past(tick_o, 2) && hdr_o.frag_seq != 8'h00
      |-> $stable(hdr_o)) else $error("header moved off tick");
   chk_frag_step: assert property ($changed(hdr_o.frag_seq)
      && $stable(hdr_o.item_seq)
      && hdr_o.frag_seq != 8'h00 && $past(hdr_o.frag_seq) != 8'h00
      |-> hdr_o.frag_seq == $past(hdr_o.frag_seq) + 8'h01) else $error("fragment step");
   chk_item_first: assert property ($changed(hdr_o.item_seq)
      && hdr_o.item_seq != 8'h00
      |-> hdr_o.frag_seq == 8'h01) else $error("new item not fragment one");
   chk_frag_size: assert property (hdr_o.frag_seq != 8'h00
      |-> hdr_o.frag_size ==
      ((hdr_o.item_size - sent > 16'h0080) ? 16'h0080 : hdr_o.item_size - sent))
      else $error("fragment size");
   chk_size_hold: assert property ($changed(hdr_o.item_size)
      && hdr_o.frag_seq != 8'h00
      |-> $changed(hdr_o.item_seq)) else $error("item size moved");
   chk_tick_gap: assert property (tick_o |=> !tick_o [*8])
      else $error("ticks too close");
   chk_data_tail: assert property (hdr_o.frag_seq != 8'h00
      |-> (frag_data_o >> {hdr_o.frag_size, 3'b000}) == '0) else $error("bytes past size");
endmodule
bind frh_framer frh_properties i_frh_properties (.core_clk_i, .arst_n_i, .cfg_instance_i,
   .cfg_accept_o, .hdr_o, .frag_data_o, .tick_o);
`default_nettype wire

// >>> tb/frh_plc_model.sv
// Purpose: controller model answering each presented fragment
// Assumes: acknowledges after a short or long lag
// Notes: fields stand as levels until the next answer
`timescale 1ns/1ps
`default_nettype none
module frh_plc_model
   import frh_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic en_i,
   input wire logic slow_i,
   input wire frh_pkg::frh_hdr_type hdr_i,
   output frh_pkg::frh_ack_type ack_o
);
   frh_hdr_type seen;
   int lag;
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seen <= '0;
         lag <= 0;
         ack_o <= '0;
      end else if (en_i && hdr_i.item_seq != 8'h00 && hdr_i != seen) begin
         if (lag < (slow_i ? 60 : 2)) begin
            lag <= lag + 1;
         end else begin
            lag <= 0;
            seen <= hdr_i;
            // item ack withheld until the remainder is in hand
            if (hdr_i.item_size > 16'(hdr_i.frag_seq) * 16'h0080) begin
               ack_o.ack_frag <= hdr_i.frag_seq;
            end else begin
               ack_o <= '{ack_item: hdr_i.item_seq, ack_frag: 8'h00};
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/fragmented_result_handshake_bench.sv
// Purpose: self-checking bench for the framer
// Assumes: short packet interval of 20 cycles
// Notes: two runs, items queued together then far apart, then the three keep settings
`timescale 1ns/1ps
`default_nettype none
module fragmented_result_handshake_bench;
   import frh_pkg::*;
   logic core_clk_i = 0, arst_n_i = 0, conn_open_i = 1, wr_byte_valid_i = 0, wr_commit_i = 0;
   logic en = 0, slow = 0, cfg_accept_o, wr_ready_o, tick_o;
   frh_keep_type keep_mode_i = FRH_KEEP_ALWAYS;
   logic [7:0] cfg_instance_i = 8'h00, wr_byte_i = 8'h00;
   logic [15:0] wr_len_i = 16'h0000;
   frh_ack_type ack_i;
   frh_hdr_type hdr_o;
   logic [FRAG_BYTES*8-1:0] frag_data_o;
   int n_mismatch = 0, cmp_count = 0;
   // 20-cycle interval keeps the run short; a real controller sits near 50 ms
   frh_framer #(.RPI_CYC(20)) i_frh_framer (.core_clk_i, .arst_n_i, .keep_mode_i, .conn_open_i,
      .cfg_instance_i, .cfg_accept_o, .wr_byte_valid_i, .wr_byte_i, .wr_commit_i, .wr_len_i,
      .wr_ready_o, .ack_i, .hdr_o, .frag_data_o, .tick_o);
   frh_plc_model i_frh_plc_model (.core_clk_i, .arst_n_i, .en_i(en), .slow_i(slow),
      .hdr_i(hdr_o), .ack_o(ack_i));
   initial forever #10 core_clk_i = ~core_clk_i;
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic push(input int len);
      @(negedge core_clk_i);
      check(wr_ready_o, 1);
      for (int k = 0; k < len; k++) begin
         @(posedge core_clk_i);
         wr_byte_valid_i <= 1;
         wr_byte_i <= 8'(k) ^ 8'h5A;
      end
      @(posedge core_clk_i);
      wr_byte_valid_i <= 0;
      wr_commit_i <= 1;
      wr_len_i <= 16'(len);
      @(posedge core_clk_i);
      wr_commit_i <= 0;
   endtask
   task automatic expect_frag(input int item, input int len, input int f);
      int n, sz, base;
      n = 0;
      base = 128 * (f - 1);
      sz = (len - base > 128) ? 128 : len - base;
      // look only between edges, never in the time step that moves the outputs
      do begin
         @(negedge core_clk_i);
         n++;
      end while (!(hdr_o.item_seq === 8'(item) && hdr_o.frag_seq === 8'(f)) && n < 3000);
      if (!(hdr_o.item_seq === 8'(item) && hdr_o.frag_seq === 8'(f))) begin
         n_mismatch++;
         finish_test;
      end
      check({hdr_o.item_size, hdr_o.frag_size}, {16'(len), 16'(sz)});
      check(frag_data_o[7:0], 8'(base) ^ 8'h5A);
      check(frag_data_o[8*sz-1 -: 8], 8'(base + sz - 1) ^ 8'h5A);
   endtask
   task automatic run_items(input int first, input bit apart);
      // quick run: the controller stays silent so item two queues before item one is read
      en <= apart;
      push(100);
      if (apart) expect_frag(first, 100, 1);
      push(800);
      en <= 1;
      expect_frag(first, 100, 1);
      for (int f = 1; f <= 7; f++) expect_frag(first + 1, 800, f);
   endtask
   task automatic retention;
      // let the controller read the last fragment of item four first
      repeat (120) @(posedge core_clk_i);
      conn_open_i <= 0;
      repeat (40) @(posedge core_clk_i);
      conn_open_i <= 1;
      @(negedge core_clk_i);
      check(frag_data_o[7:0], 8'(768) ^ 8'h5A);
      @(posedge core_clk_i);
      keep_mode_i <= FRH_DISCARD_ON_DISCONNECT;
      repeat (40) @(posedge core_clk_i);
      conn_open_i <= 0;
      @(negedge core_clk_i);
      check(frag_data_o[7:0], 8'(768) ^ 8'h5A);
      repeat (8) @(posedge core_clk_i);
      conn_open_i <= 1;
      keep_mode_i <= FRH_DISCARD_ON_READ;
      @(negedge core_clk_i);
      check(frag_data_o[7:0], 8'h00);
      push(100);
      expect_frag(5, 100, 1);
      repeat (200) @(negedge core_clk_i);
      check(frag_data_o[7:0], 8'h00);
   endtask
   initial begin
      repeat (8) @(posedge core_clk_i);
      arst_n_i <= 1;
      @(negedge core_clk_i);
      check(hdr_o, 48'h0);
      @(posedge core_clk_i);
      cfg_instance_i <= 8'h80;
      @(negedge core_clk_i);
      check(cfg_accept_o, 1);
      @(posedge core_clk_i);
      cfg_instance_i <= 8'h7F;
      en <= 1;
      @(negedge core_clk_i);
      check(cfg_accept_o, 0);
      run_items(1, 0);
      slow <= 1;
      run_items(3, 1);
      retention;
      finish_test;
   end
endmodule
`default_nettype wire
